// ---- inc/jtp_pkg.sv ----
// constants, instruction codes and controller states of the test access port
`default_nettype none
package jtp_pkg;

    // instruction register width and the scan width of the user register
    localparam int IR_W = 4;
    localparam int DR_W = 32;

    // instruction codes; any code not listed acts as bypass
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] INS_USER = 4'h2;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;

    // pattern loaded into the instruction shifter in capture-ir
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    // reset values
    localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;
    localparam logic [DR_W-1:0] USER_RESET = 32'h0000_0000;
    localparam logic [DR_W-1:0] SHIFT_RESET = 32'h0000_0000;

    // identification word; value is arbitrary, bit 0 must stay set
    localparam logic [31:0] IDCODE_DEFAULT = 32'h0000_1001;

    // the sixteen controller states
    typedef enum logic [3:0] {
        ST_TLR,
        ST_RTI,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SH_DR,
        ST_EX1_DR,
        ST_PAU_DR,
        ST_EX2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SH_IR,
        ST_EX1_IR,
        ST_PAU_IR,
        ST_EX2_IR,
        ST_UPD_IR
    } jtp_state_t;

endpackage
`default_nettype wire

// ---- rtl/jtp_tap_fsm.sv ----
// sixteen-state test controller, advanced by the mode select on rising test clock
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_fsm (
    input wire logic tck,
    input wire logic rst,
    input wire logic tms,
    output var jtp_pkg::jtp_state_t state
);

    typedef struct packed {
        jtp_pkg::jtp_state_t st;
    } jtp_fsm_regs_t;

    jtp_fsm_regs_t r_q;
    jtp_fsm_regs_t r_d;

    // next state from the sampled mode select
    always_comb
    begin
        r_d = r_q;
        case (r_q.st)
            jtp_pkg::ST_TLR: r_d.st = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_RTI;
            jtp_pkg::ST_RTI: r_d.st = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
            jtp_pkg::ST_SEL_DR: r_d.st = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
            jtp_pkg::ST_CAP_DR: r_d.st = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_SH_DR: r_d.st = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_EX1_DR: r_d.st = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
            jtp_pkg::ST_PAU_DR: r_d.st = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
            jtp_pkg::ST_EX2_DR: r_d.st = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_UPD_DR: r_d.st = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
            jtp_pkg::ST_SEL_IR: r_d.st = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_CAP_IR;
            jtp_pkg::ST_CAP_IR: r_d.st = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_SH_IR: r_d.st = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_EX1_IR: r_d.st = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
            jtp_pkg::ST_PAU_IR: r_d.st = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
            jtp_pkg::ST_EX2_IR: r_d.st = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_UPD_IR: r_d.st = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
            default: r_d.st = jtp_pkg::ST_TLR;
        endcase
        if (rst)
        begin
            r_d.st = jtp_pkg::ST_TLR;
        end
    end

    // state register on the rising test clock
    always_ff @(posedge tck)
    begin
        r_q <= r_d;
    end

    assign state = r_q.st;

endmodule
`default_nettype wire

// ---- rtl/jtp_tap.sv ----
// test access port: controller, instruction and data scan paths, test data output
// Functional notes
// - test data input is captured on rising test clock edges into a shifter only in shift-ir and shift-dr
// - mode select is sampled on rising test clock edges to step the controller
// - test data output changes only on falling test clock edges
// - test data output is driven only in shift-ir and shift-dr
// - output is high impedance in all other states and while in reset
`timescale 1ns/1ps
`default_nettype none
module jtp_tap #(
    parameter logic [31:0] IDCODE = jtp_pkg::IDCODE_DEFAULT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic [jtp_pkg::DR_W-1:0] upd_word,
    output logic upd_pulse
);

    // rising test clock domain state
    typedef struct packed {
        logic rs_meta;
        logic rs;
        logic [jtp_pkg::IR_W-1:0] ir_sh;
        logic [jtp_pkg::IR_W-1:0] ir;
        logic [jtp_pkg::DR_W-1:0] dr_sh;
        logic byp;
        logic [jtp_pkg::DR_W-1:0] user;
        logic upd_tgl;
    } jtp_rise_t;

    // falling test clock domain state
    typedef struct packed {
        logic tdo;
        logic oe_n;
    } jtp_fall_t;

    // system clock domain state
    typedef struct packed {
        logic tgl_meta;
        logic tgl_s2;
        logic tgl_s3;
        logic [jtp_pkg::DR_W-1:0] word;
        logic pulse;
    } jtp_sys_t;

    jtp_rise_t t_q;
    jtp_rise_t t_d;
    jtp_fall_t n_q;
    jtp_fall_t n_d;
    jtp_sys_t s_q;
    jtp_sys_t s_d;
    jtp_pkg::jtp_state_t st;

    // true when the instruction routes the wide shifter to the output
    function automatic logic uses_wide(input logic [jtp_pkg::IR_W-1:0] ins);
        uses_wide = (ins == jtp_pkg::INS_IDCODE) || (ins == jtp_pkg::INS_USER);
    endfunction

    // controller, stepped by the sampled mode select
    jtp_tap_fsm u_fsm (
        .tck(tck),
        .rst(t_q.rs),
        .tms(tms),
        .state(st)
    );

    // scan path actions on the rising test clock
    always_comb
    begin
        t_d = t_q;
        t_d.rs_meta = srst; // reset carried into the test clock domain
        t_d.rs = t_q.rs_meta;
        case (st)
            jtp_pkg::ST_TLR:
            begin
                t_d.ir = jtp_pkg::IR_RESET;
            end
            jtp_pkg::ST_CAP_IR:
            begin
                t_d.ir_sh = jtp_pkg::IR_CAPTURE;
            end
            jtp_pkg::ST_SH_IR:
            begin
                t_d.ir_sh = {tdi, t_q.ir_sh[jtp_pkg::IR_W-1:1]};
            end
            jtp_pkg::ST_UPD_IR:
            begin
                t_d.ir = t_q.ir_sh;
            end
            jtp_pkg::ST_CAP_DR:
            begin
                t_d.byp = 1'b0;
                if (t_q.ir == jtp_pkg::INS_IDCODE)
                begin
                    t_d.dr_sh = IDCODE;
                end
                else if (t_q.ir == jtp_pkg::INS_USER)
                begin
                    t_d.dr_sh = t_q.user; // reads back the last update
                end
            end
            jtp_pkg::ST_SH_DR:
            begin
                if (uses_wide(t_q.ir))
                begin
                    t_d.dr_sh = {tdi, t_q.dr_sh[jtp_pkg::DR_W-1:1]};
                end
                else
                begin
                    t_d.byp = tdi;
                end
            end
            jtp_pkg::ST_UPD_DR:
            begin
                if (t_q.ir == jtp_pkg::INS_USER)
                begin
                    t_d.user = t_q.dr_sh;
                    t_d.upd_tgl = ~t_q.upd_tgl; // event toward system clock
                end
            end
            default:
            begin
            end
        endcase
        if (t_q.rs)
        begin
            t_d.ir_sh = jtp_pkg::IR_CAPTURE;
            t_d.ir = jtp_pkg::IR_RESET;
            t_d.dr_sh = jtp_pkg::SHIFT_RESET;
            t_d.byp = 1'b0;
            t_d.user = jtp_pkg::USER_RESET;
            t_d.upd_tgl = 1'b0;
        end
    end

    // rising test clock register
    always_ff @(posedge tck)
    begin
        t_q <= t_d;
    end

    // output bit and its enable, chosen from the current state
    always_comb
    begin
        n_d = n_q;
        n_d.oe_n = !((st == jtp_pkg::ST_SH_IR) || (st == jtp_pkg::ST_SH_DR));
        if (st == jtp_pkg::ST_SH_IR)
        begin
            n_d.tdo = t_q.ir_sh[0];
        end
        else if (uses_wide(t_q.ir))
        begin
            n_d.tdo = t_q.dr_sh[0];
        end
        else
        begin
            n_d.tdo = t_q.byp;
        end
        if (t_q.rs)
        begin
            n_d.tdo = 1'b0;
            n_d.oe_n = 1'b1;
        end
    end

    // output changes half a test clock before the external controller samples it
    always_ff @(negedge tck)
    begin
        n_q <= n_d;
    end

    assign tdo = n_q.tdo;
    assign tdo_oe_n = n_q.oe_n;

    // update toggle synchronised, edge seen on stable stages, word latched
    always_comb
    begin
        s_d = s_q;
        s_d.tgl_meta = t_q.upd_tgl;
        s_d.tgl_s2 = s_q.tgl_meta;
        s_d.tgl_s3 = s_q.tgl_s2;
        s_d.pulse = s_q.tgl_s2 ^ s_q.tgl_s3;
        if (s_q.tgl_s2 ^ s_q.tgl_s3)
        begin
            s_d.word = t_q.user; // held stable for several test clocks
        end
        if (srst)
        begin
            s_d.tgl_meta = 1'b0;
            s_d.tgl_s2 = 1'b0;
            s_d.tgl_s3 = 1'b0;
            s_d.word = jtp_pkg::USER_RESET;
            s_d.pulse = 1'b0;
        end
    end

    // system clock register
    always_ff @(posedge clock)
    begin
        s_q <= s_d;
    end

    assign upd_word = s_q.word;
    assign upd_pulse = s_q.pulse;

endmodule
`default_nettype wire

// ---- bench/jtp_tap_monitor.sv ----
// pin checker for the test access port
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_monitor (
    input wire logic clock,
    input wire logic srst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    input wire logic [jtp_pkg::DR_W-1:0] upd_word,
    input wire logic upd_pulse
);
    // test data output and its enable move only while the test clock is low
    a_oe_on_fall: assert property (
        @(posedge clock) disable iff (srst) $changed(tdo_oe_n) |-> !tck)
        else $error("enable moved with test clock high");
    a_tdo_on_fall: assert property (
        @(posedge clock) disable iff (srst) $changed(tdo) |-> !tck)
        else $error("data moved with test clock high");
    // five high mode samples leave the pin released
    a_five_high_hiz: assert property (
        @(posedge tck) disable iff (srst) tms [*5] |=> tdo_oe_n)
        else $error("pin driven after five high mode samples");
    // driving starts only after select, capture, shift
    a_drive_after_capture: assert property (
        @(posedge tck) disable iff (srst)
        $fell(tdo_oe_n) |-> !$past(tms) && !$past(tms, 2) && $past(tms, 3))
        else $error("pin driven outside a shift state");
    a_drive_low_mode: assert property (
        @(posedge tck) disable iff (srst) !tdo_oe_n |-> !$past(tms))
        else $error("pin driven after a high mode sample");
    a_release_on_exit: assert property (
        @(posedge tck) disable iff (srst) $rose(tdo_oe_n) |-> $past(tms))
        else $error("pin released inside a shift state");
    a_reset_hiz: assert property (
        @(posedge tck) srst [*4] |-> tdo_oe_n)
        else $error("pin driven during reset");
    // main scenarios
    c_update: cover property (@(posedge clock) upd_pulse);
    c_shift: cover property (@(posedge tck) $fell(tdo_oe_n));
    c_reset: cover property (@(posedge tck) srst [*4]);
endmodule
bind jtp_tap jtp_tap_monitor i_mon (.clock, .srst, .tck, .tms, .tdi, .tdo,
    .tdo_oe_n, .upd_word, .upd_pulse);
`default_nettype wire

// ---- bench/jtp_ctrl_model.sv ----
// behavioural external test controller on the link pins
`timescale 1ns/1ps
`default_nettype none
module jtp_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic last_q = 1'b0;
    initial
    begin
        tck = 0;
        tms = 1;
        tdi = 0;
    end
    // one test clock period; pins change after the falling edge
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #24 tck = 1;
        // a released pin shows no stale value
        o = tdo_oe_n ? ~last_q : tdo;
        last_q = o;
        #24 tck = 0;
    endtask
    // scan n bits lsb first through ir or dr, ending in idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1, 0, o);
        if (ir)
            tick(1, 0, o);
        tick(0, 0, o);
        tick(0, 0, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1, 0, o);
        tick(0, 0, o);
    endtask
endmodule
`default_nettype wire

// ---- bench/jtp_tap_test.sv ----
// self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_test;
    localparam logic [31:0] IDC = 32'h0000_5A3B; // arbitrary identification word
    logic clock = 0;
    logic srst = 1;
    logic tck, tms, tdi, tdo, tdo_oe_n, upd_pulse, o;
    logic [jtp_pkg::DR_W-1:0] upd_word;
    logic [31:0] r;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    jtp_tap #(.IDCODE(IDC)) i_dut (.clock, .srst, .tck, .tms, .tdi, .tdo,
        .tdo_oe_n, .upd_word, .upd_pulse);
    jtp_ctrl_model i_ctrl (.tck, .tms, .tdi, .tdo, .tdo_oe_n);
    // value compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end
    // bounded wait for the update pulse, then the word
    task automatic wait_upd(input logic [31:0] exp);
        int n = 0;
        // step off the launching edge before the first look
        do
        begin
            @(negedge clock);
            n++;
        end
        while (upd_pulse !== 1'b1 && n < 10);
        chk("update pulse", 1, upd_pulse);
        chk("update word", exp, upd_word);
    endtask
    // five high mode samples from shift-ir bring back the id instruction
    task automatic t_tlr();
        i_ctrl.tick(1, 0, o);
        i_ctrl.tick(1, 0, o);
        i_ctrl.tick(0, 0, o);
        i_ctrl.tick(0, 0, o);
        #1 chk("enable in shift-ir", 0, tdo_oe_n);
        repeat (5) i_ctrl.tick(1, 0, o);
        #1 chk("enable after reset walk", 1, tdo_oe_n);
        i_ctrl.tick(0, 0, o);
        i_ctrl.scan(0, 32, 0, r);
        chk("id word after reset walk", IDC, r);
    endtask
    task automatic t_user();
        i_ctrl.scan(1, 4, 2, r);
        chk("ir capture", 1, r[3:0]);
        i_ctrl.scan(0, 32, 32'hA5C3_0F96, r);
        chk("user capture", 0, r);
        wait_upd(32'hA5C3_0F96);
        i_ctrl.scan(0, 32, 32'h3C69_F00D, r);
        chk("user echo", 32'hA5C3_0F96, r);
        wait_upd(32'h3C69_F00D);
    endtask
    task automatic t_idcode();
        i_ctrl.scan(1, 4, 1, r);
        i_ctrl.scan(0, 32, 0, r);
        chk("id word", IDC, r);
    endtask
    // listed bypass code and an unlisted one
    task automatic t_bypass();
        for (int k = 0; k < 2; k++)
        begin
            i_ctrl.scan(1, 4, (k == 1) ? 32'h0000_0007 : 32'h0000_000F, r);
            i_ctrl.scan(0, 2, 1, r);
            chk("bypass bits", 2, r);
        end
    endtask
    // reset in mid shift releases the pin
    task automatic t_reset_mid();
        i_ctrl.tick(1, 0, o);
        i_ctrl.tick(0, 0, o);
        i_ctrl.tick(0, 0, o);
        #1 chk("enable in shift", 0, tdo_oe_n);
        @(negedge clock) srst = 1;
        repeat (5) i_ctrl.tick(0, 0, o);
        #1 chk("enable in reset", 1, tdo_oe_n);
        @(negedge clock) srst = 0;
        repeat (3) i_ctrl.tick(1, 0, o);
        i_ctrl.tick(0, 0, o);
        chk("word after reset", 0, upd_word);
    endtask
    // the test clock runs while reset is high, so the link side resets too
    initial
    begin
        repeat (3) i_ctrl.tick(1, 0, o);
        @(negedge clock) srst = 0;
        repeat (3) i_ctrl.tick(1, 0, o);
        i_ctrl.tick(0, 0, o);
        t_user();
        t_tlr();
        t_idcode();
        t_bypass();
        t_reset_mid();
        report_and_stop();
    end
endmodule
`default_nettype wire
